//--- rtl/equalizer_pkg.sv
// Shared constants, field layouts and carrier types for the equalizer control bank
package equalizer_pkg;

  // ==========================================================================
  // Register addresses (byte-wide registers on the serial command port)
  localparam logic [3:0] ADDR_CONTROL        = 4'h0;
  localparam logic [3:0] ADDR_THRESHOLD      = 4'h1;
  localparam logic [3:0] ADDR_DEEMPHASIS     = 4'h2;
  localparam logic [3:0] ADDR_RATE           = 4'h7;
  localparam logic [3:0] ADDR_RSVD_EIGHT     = 4'h8;
  localparam logic [3:0] ADDR_RSVD_NINE      = 4'h9;
  localparam logic [3:0] ADDR_RSVD_TEN       = 4'ha;
  localparam logic [3:0] ADDR_LOSS_LEVEL     = 4'hb;
  localparam logic [3:0] ADDR_RSVD_TWELVE    = 4'hc;
  localparam logic [3:0] ADDR_RSVD_THIRTEEN  = 4'hd;
  localparam logic [3:0] ADDR_RATE_READBACK  = 4'he;
  localparam logic [3:0] ADDR_LOSS_READBACK  = 4'hf;

  // ==========================================================================
  // Control register bit positions
  localparam int CTL_LOSS_LEVEL_PIN_SEL = 7;
  localparam int CTL_SWING_PIN_SEL      = 6;
  localparam int CTL_DEEMPH_PIN_SEL     = 5;
  localparam int CTL_THRESHOLD_PIN_SEL  = 4;
  localparam int CTL_OUTPUT_DISABLE     = 3;
  localparam int CTL_LOSS_RANGE_HIGH    = 2;
  localparam int CTL_OFFSET_CANCEL_DIS  = 1;
  localparam int CTL_REGISTER_CONTROL   = 0;

  // Rate and loss-level register select flags
  localparam int RATE_SELECT_BIT        = 7;
  localparam int LOSS_CODE_ENABLE_BIT   = 7;

  // ==========================================================================
  // Writable bit masks; everything else reads zero and ignores writes
  localparam logic [7:0] MASK_CONTROL    = 8'hff;
  localparam logic [7:0] MASK_THRESHOLD  = 8'hff;
  localparam logic [7:0] MASK_DEEMPHASIS = 8'h0f;
  localparam logic [7:0] MASK_RATE       = 8'h8f;
  localparam logic [7:0] MASK_LOSS_LEVEL = 8'hff;

  // Reset values
  localparam logic [7:0] RST_CONTROL    = 8'h00;
  localparam logic [7:0] RST_THRESHOLD  = 8'h00;
  localparam logic [7:0] RST_DEEMPHASIS = 8'h00;
  localparam logic [7:0] RST_RATE       = 8'h00;
  localparam logic [7:0] RST_LOSS_LEVEL = 8'h00;

  // ==========================================================================
  // Fixed settings applied when a select flag is clear
  localparam logic [3:0] BANDWIDTH_FIXED_CODE  = 4'h0;
  localparam logic [6:0] LOSS_LEVEL_FIXED_CODE = 7'h00;

  // Threshold code of exact midpoint and code zero, both giving no shift
  localparam logic [7:0] THRESHOLD_MID  = 8'h80;
  localparam logic [7:0] THRESHOLD_ZERO = 8'h00;

  // De-emphasis codes, each a step of 0.875 dB above the previous
  localparam logic [3:0] DEEM_CODE_0 = 4'h0;
  localparam logic [3:0] DEEM_CODE_1 = 4'h1;
  localparam logic [3:0] DEEM_CODE_2 = 4'h3;
  localparam logic [3:0] DEEM_CODE_3 = 4'h4;
  localparam logic [3:0] DEEM_CODE_4 = 4'h5;
  localparam logic [3:0] DEEM_CODE_5 = 4'h7;
  localparam logic [3:0] DEEM_CODE_6 = 4'hc;
  localparam logic [3:0] DEEM_CODE_7 = 4'hd;
  localparam logic [3:0] DEEM_CODE_8 = 4'hf;

  // ==========================================================================
  // Pin-derived settings presented by the analog front end
  typedef struct packed {
    logic [6:0] loss_level_voltage_pin;
    logic [7:0] threshold_voltage_pin;
    logic [1:0] emphasis_pins;
    logic       output_disable_pin;
    logic       loss_range_pin;
  } pin_set_t;

  // Effective settings driven into the datapath
  typedef struct packed {
    logic       output_disable;
    logic       loss_range_high;
    logic       offset_cancel_disable;
    logic       swing_reg_active;
    logic       deemph_reg_active;
    logic [3:0] deemph_code;
    logic [3:0] deemph_steps;
    logic       threshold_reg_active;
    logic [7:0] threshold_code;
    logic       threshold_shift_neg;
    logic [6:0] threshold_shift_mag;
    logic       bandwidth_from_code;
    logic [3:0] bandwidth_code;
    logic       loss_level_reg_active;
    logic [6:0] loss_level_code;
  } eff_set_t;

endpackage

//--- rtl/masked_byte_reg.sv
// One writable byte of the control bank with its own write mask and reset value
`timescale 1ns/1ps

module masked_byte_reg #(
  parameter logic [7:0] MASK      = 8'hff,
  parameter logic [7:0] RST_VALUE = 8'h00
) (
  // Clock and control
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_clk_en,
  // Write side
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  // Stored value
  output logic [7:0]      o_value
);

  // ==========================================================================
  // Storage
  // Masked bits never store, so unused positions read back as zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_value <= RST_VALUE & MASK;
    end else if (i_clk_en && i_wr) begin
      o_value <= i_wdata & MASK;
    end
  end

endmodule

//--- rtl/equalizer_control_register_bank.sv
// Control register bank of the equalizer: storage, source selection, readback
`timescale 1ns/1ps

// What this block does
// - Bit 7 picks loss level pin or register
// - Bit 6 picks swing pin or register
// - Bit 5 picks de-emphasis pins or register
// - Bit 4 picks threshold pin or register
// - Bit 3 disables output, resets to enabled
// - Bit 2 picks high loss range, reset low
// - Bit 1 disables offset cancellation, reset enabled
// - Bit 0 enables register control, reset pins
// - Threshold codes 0 and 128 give zero shift
// - Codes 1 to 127 shift positive, decreasing
// - Codes 129 to 255 shift negative, increasing
// - De-emphasis code maps to 0.875 dB steps
// - Rate register: flag bit 7, code 3:0
// - Loss register: flag bit 7, code 6:0
// - Readback of selected bandwidth code
// - Readback of selected loss assert level
// - Addresses 8,9,10,12,13 exist without fields
// - Rate flag clear uses fixed bandwidth
// - Bandwidth code 0 maximum, 15 minimum
// - Loss flag set applies code, else default
module equalizer_control_register_bank (
  // Clock, reset, enable
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_clk_en,
  // Register command port from the serial protocol engine
  input  wire logic [3:0]             i_reg_addr,
  input  wire logic                   i_reg_wr,
  input  wire logic [7:0]             i_reg_wdata,
  input  wire logic                   i_reg_rd,
  output logic [7:0]                  o_reg_rdata,
  output logic                        o_reg_rvalid,
  output logic                        o_reg_hit,
  // Pin-derived settings
  input  wire equalizer_pkg::pin_set_t i_pins,
  // Effective settings to the datapath
  output equalizer_pkg::eff_set_t     o_eff
);

  import equalizer_pkg::*;

  // ==========================================================================
  // Helper functions
  // A register-held setting applies only in register mode with its pin select clear
  function automatic logic reg_wins(input logic mode, input logic pin_sel);
    reg_wins = mode && !pin_sel;
  endfunction

  // Threshold code: sign and magnitude of the shift
  function automatic logic [7:0] threshold_shift(input logic [7:0] code);
    logic [7:0] diff;
    diff = 8'h00;
    if (code == THRESHOLD_ZERO || code == THRESHOLD_MID) begin
      threshold_shift = 8'h00;
    end else if (!code[7]) begin
      diff = THRESHOLD_MID - code;
      threshold_shift = {1'b0, diff[6:0]};
    end else begin
      diff = code - THRESHOLD_MID;
      threshold_shift = {1'b1, diff[6:0]};
    end
  endfunction

  // De-emphasis code to count of 0.875 dB steps; unlisted codes give none
  function automatic logic [3:0] deemph_steps(input logic [3:0] code);
    case (code)
      DEEM_CODE_0: deemph_steps = 4'h0;
      DEEM_CODE_1: deemph_steps = 4'h1;
      DEEM_CODE_2: deemph_steps = 4'h2;
      DEEM_CODE_3: deemph_steps = 4'h3;
      DEEM_CODE_4: deemph_steps = 4'h4;
      DEEM_CODE_5: deemph_steps = 4'h5;
      DEEM_CODE_6: deemph_steps = 4'h6;
      DEEM_CODE_7: deemph_steps = 4'h7;
      DEEM_CODE_8: deemph_steps = 4'h8;
      default:     deemph_steps = 4'h0;
    endcase
  endfunction

  // ==========================================================================
  // Writable registers
  logic [7:0] control_settings;
  logic [7:0] input_threshold_adjust;
  logic [7:0] deemphasis_setting;
  logic [7:0] max_data_rate_setting;
  logic [7:0] loss_level_setting;

  logic       wr_control;
  logic       wr_threshold;
  logic       wr_deemphasis;
  logic       wr_rate;
  logic       wr_loss_level;

  // Read-only and reserved addresses have no write decode at all
  assign wr_control    = i_reg_wr && (i_reg_addr == ADDR_CONTROL);
  assign wr_threshold  = i_reg_wr && (i_reg_addr == ADDR_THRESHOLD);
  assign wr_deemphasis = i_reg_wr && (i_reg_addr == ADDR_DEEMPHASIS);
  assign wr_rate       = i_reg_wr && (i_reg_addr == ADDR_RATE);
  assign wr_loss_level = i_reg_wr && (i_reg_addr == ADDR_LOSS_LEVEL);

  masked_byte_reg #(.MASK(MASK_CONTROL), .RST_VALUE(RST_CONTROL)) u_control (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .i_wr      (wr_control),
    .i_wdata   (i_reg_wdata),
    .o_value   (control_settings)
  );

  masked_byte_reg #(.MASK(MASK_THRESHOLD), .RST_VALUE(RST_THRESHOLD)) u_threshold (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .i_wr      (wr_threshold),
    .i_wdata   (i_reg_wdata),
    .o_value   (input_threshold_adjust)
  );

  masked_byte_reg #(.MASK(MASK_DEEMPHASIS), .RST_VALUE(RST_DEEMPHASIS)) u_deemph (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .i_wr      (wr_deemphasis),
    .i_wdata   (i_reg_wdata),
    .o_value   (deemphasis_setting)
  );

  masked_byte_reg #(.MASK(MASK_RATE), .RST_VALUE(RST_RATE)) u_rate (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .i_wr      (wr_rate),
    .i_wdata   (i_reg_wdata),
    .o_value   (max_data_rate_setting)
  );

  masked_byte_reg #(.MASK(MASK_LOSS_LEVEL), .RST_VALUE(RST_LOSS_LEVEL)) u_loss (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .i_wr      (wr_loss_level),
    .i_wdata   (i_reg_wdata),
    .o_value   (loss_level_setting)
  );

  // ==========================================================================
  // Source selection
  logic       register_control_enable;
  logic       loss_level_pin_select;
  logic       swing_pin_select;
  logic       deemph_pin_select;
  logic       threshold_pin_select;
  logic       loss_level_code_enable;
  logic [7:0] thr_shift;
  eff_set_t   next_eff;

  assign register_control_enable = control_settings[CTL_REGISTER_CONTROL];
  assign loss_level_pin_select   = control_settings[CTL_LOSS_LEVEL_PIN_SEL];
  assign swing_pin_select        = control_settings[CTL_SWING_PIN_SEL];
  assign deemph_pin_select       = control_settings[CTL_DEEMPH_PIN_SEL];
  assign threshold_pin_select    = control_settings[CTL_THRESHOLD_PIN_SEL];
  assign loss_level_code_enable  = loss_level_setting[LOSS_CODE_ENABLE_BIT];

  always_comb begin
    next_eff = '0;
    thr_shift = 8'h00;
    // Output disable and loss range fall back to their pins outside register mode; offset cancel disable goes to 0
    if (register_control_enable) begin
      next_eff.output_disable        = control_settings[CTL_OUTPUT_DISABLE];
      next_eff.loss_range_high       = control_settings[CTL_LOSS_RANGE_HIGH];
      next_eff.offset_cancel_disable = control_settings[CTL_OFFSET_CANCEL_DIS];
    end else begin
      next_eff.output_disable        = i_pins.output_disable_pin;
      next_eff.loss_range_high       = i_pins.loss_range_pin;
      next_eff.offset_cancel_disable = 1'b0;
    end

    next_eff.swing_reg_active = reg_wins(register_control_enable, swing_pin_select);

    // De-emphasis: pin pair zero-extended when the pins drive it
    next_eff.deemph_reg_active = reg_wins(register_control_enable, deemph_pin_select);
    if (next_eff.deemph_reg_active) begin
      next_eff.deemph_code  = deemphasis_setting[3:0];
      next_eff.deemph_steps = deemph_steps(deemphasis_setting[3:0]);
    end else begin
      next_eff.deemph_code  = {2'b00, i_pins.emphasis_pins};
      next_eff.deemph_steps = 4'h0;
    end

    // Threshold: the pin code follows the same encoding as the register
    next_eff.threshold_reg_active = reg_wins(register_control_enable, threshold_pin_select);
    if (next_eff.threshold_reg_active) begin
      next_eff.threshold_code = input_threshold_adjust;
    end else begin
      next_eff.threshold_code = i_pins.threshold_voltage_pin;
    end
    thr_shift = threshold_shift(next_eff.threshold_code);
    next_eff.threshold_shift_neg = thr_shift[7];
    next_eff.threshold_shift_mag = thr_shift[6:0];

    // Bandwidth has no pin; code 0 is widest, 15 narrowest
    next_eff.bandwidth_from_code = register_control_enable &&
                                   max_data_rate_setting[RATE_SELECT_BIT];
    if (next_eff.bandwidth_from_code) begin
      next_eff.bandwidth_code = max_data_rate_setting[3:0];
    end else begin
      next_eff.bandwidth_code = BANDWIDTH_FIXED_CODE;
    end

    // Loss level: pin, fixed default, or register code
    next_eff.loss_level_reg_active = reg_wins(register_control_enable, loss_level_pin_select);
    if (!next_eff.loss_level_reg_active) begin
      next_eff.loss_level_code = i_pins.loss_level_voltage_pin;
    end else if (loss_level_code_enable) begin
      next_eff.loss_level_code = loss_level_setting[6:0];
    end else begin
      next_eff.loss_level_code = LOSS_LEVEL_FIXED_CODE;
    end
  end

  // ==========================================================================
  // Effective settings register
  // Registered so the datapath never sees decode glitches from a write
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_eff <= '0;
    end else if (i_clk_en) begin
      o_eff <= next_eff;
    end
  end

  // ==========================================================================
  // Read path
  logic [7:0] next_rdata;
  logic       next_hit;

  always_comb begin
    next_rdata = 8'h00;
    next_hit   = 1'b1;
    case (i_reg_addr)
      ADDR_CONTROL:       next_rdata = control_settings;
      ADDR_THRESHOLD:     next_rdata = input_threshold_adjust;
      ADDR_DEEMPHASIS:    next_rdata = deemphasis_setting;
      ADDR_RATE:          next_rdata = max_data_rate_setting;
      ADDR_LOSS_LEVEL:    next_rdata = loss_level_setting;
      ADDR_RATE_READBACK: next_rdata = {4'h0, o_eff.bandwidth_code};
      ADDR_LOSS_READBACK: next_rdata = {1'b0, o_eff.loss_level_code};
      ADDR_RSVD_EIGHT, ADDR_RSVD_NINE, ADDR_RSVD_TEN,
      ADDR_RSVD_TWELVE, ADDR_RSVD_THIRTEEN: begin
        next_rdata = 8'h00;
      end
      default: begin
        next_rdata = 8'h00;
        next_hit   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
      o_reg_hit    <= 1'b0;
    end else if (i_clk_en) begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd || i_reg_wr) begin
        o_reg_hit <= next_hit;
      end
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

endmodule

//--- tb/equalizer_control_register_bank_props.sv
// Port-level assertions for the equalizer control register bank
`timescale 1ns/1ps

module equalizer_control_register_bank_props
  import equalizer_pkg::*;
(
  // Clock, reset, enable
  input wire logic                    i_ref_clk,
  input wire logic                    i_rst_b,
  input wire logic                    i_clk_en,
  // Register command port
  input wire logic [3:0]              i_reg_addr,
  input wire logic                    i_reg_wr,
  input wire logic [7:0]              i_reg_wdata,
  input wire logic                    i_reg_rd,
  input wire logic [7:0]              o_reg_rdata,
  input wire logic                    o_reg_rvalid,
  input wire logic                    o_reg_hit,
  // Settings
  input wire equalizer_pkg::pin_set_t i_pins,
  input wire equalizer_pkg::eff_set_t o_eff
);
  // ====
  // Setup
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  logic rd_t;
  logic [7:0] thr;
  assign rd_t = i_clk_en && i_reg_rd;
  assign thr  = o_eff.threshold_code;

  // ====
  // Read port
  a_read_gives_valid:
    assert property (rd_t |=> o_reg_rvalid) else $error("read not answered");
  a_valid_one_pulse:
    assert property (i_clk_en && !i_reg_rd |=> !o_reg_rvalid) else $error("stray valid");
  a_reserved_reads_zero:
    assert property (rd_t && (i_reg_addr inside {[4'h3:4'h6], 4'h8, 4'h9, 4'ha, 4'hc, 4'hd})
      |=> o_reg_rdata == 8'h00) else $error("reserved read not zero");
  a_hit_follows_map:
    assert property (i_clk_en && (i_reg_rd || i_reg_wr)
      |=> o_reg_hit == !($past(i_reg_addr) inside {[4'h3:4'h6]})) else $error("hit wrong");
  a_deemph_top_zero:
    assert property (rd_t && i_reg_addr == 4'h2 |=> o_reg_rdata[7:4] == 4'h0)
      else $error("de-emphasis upper bits set");
  a_rate_gap_zero:
    assert property (rd_t && i_reg_addr == 4'h7 |=> o_reg_rdata[6:4] == 3'h0)
      else $error("rate unused bits set");
  a_rate_readback:
    assert property (rd_t && i_reg_addr == 4'he
      |=> o_reg_rdata == {4'h0, $past(o_eff.bandwidth_code)}) else $error("rate readback");
  a_loss_readback:
    assert property (rd_t && i_reg_addr == 4'hf
      |=> o_reg_rdata == {1'b0, $past(o_eff.loss_level_code)}) else $error("loss readback");

  // ====
  // Effective settings
  a_fixed_bandwidth:
    assert property (!o_eff.bandwidth_from_code |-> o_eff.bandwidth_code == BANDWIDTH_FIXED_CODE)
      else $error("bandwidth not fixed");
  a_zero_shift:
    assert property (thr inside {8'h00, 8'h80} |-> o_eff.threshold_shift_mag == 7'h00
      && !o_eff.threshold_shift_neg) else $error("zero shift wrong");
  a_positive_shift:
    assert property (thr inside {[8'h01:8'h7f]} |-> !o_eff.threshold_shift_neg
      && o_eff.threshold_shift_mag == 7'(8'h80 - thr)) else $error("positive shift wrong");
  a_negative_shift:
    assert property (thr > 8'h80 |-> o_eff.threshold_shift_neg
      && o_eff.threshold_shift_mag == thr[6:0]) else $error("negative shift wrong");
  a_pin_threshold:
    assert property ($past(i_rst_b) && $past(i_clk_en) && !o_eff.threshold_reg_active
      |-> thr == $past(i_pins.threshold_voltage_pin)) else $error("pin threshold lost");

  c_rate_read: cover property (rd_t && i_reg_addr == 4'he);
  c_neg_shift: cover property (o_eff.threshold_shift_neg);
  c_band_code: cover property (o_eff.bandwidth_from_code);
endmodule

//--- tb/eq_host_model.sv
// Host controller model issuing byte reads and writes on the register port
`timescale 1ns/1ps

module eq_host_model (
  // Clock
  input  wire logic       i_ref_clk,
  // Register port
  output logic [3:0]      o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  initial begin
    o_addr  = 4'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  // One byte transfer; the answer is taken one cycle after the request
  task automatic xfer(input logic [3:0] a, input logic [7:0] d, input logic w,
                      input logic r, output logic [7:0] q, output logic v);
    @(negedge i_ref_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = w;
    o_rd    = r;
    @(negedge i_ref_clk);
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    // Idle data is inverted so a stale byte cannot pass for a fresh one
    o_wdata = ~d;
    q       = i_rdata;
    v       = i_rvalid;
  endtask
endmodule

//--- tb/equalizer_control_register_bank_tb.sv
// Self-checking bench for the equalizer control register bank
`timescale 1ns/1ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module equalizer_control_register_bank_tb;
  import equalizer_pkg::*;
  // ====
  // Signals
  logic       i_ref_clk = 1'b0;
  logic       i_rst_b   = 1'b0;
  logic       i_clk_en  = 1'b1;
  logic [3:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       hit;
  logic [7:0] q;
  logic       v;
  pin_set_t   pins      = {7'h55, 8'h33, 2'b10, 1'b1, 1'b1};
  eff_set_t   eff;
  logic [7:0] shadow [16] = '{default: 8'h00};
  logic [7:0] thr_codes [6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'h81, 8'hff};
  logic [7:0] sel_codes [4] = '{8'h0c, 8'hfc, 8'h80, 8'h7f};
  int         fail_count = 0;
  int         num_checks = 0;
  // Step count of each de-emphasis code, one nibble per code
  localparam logic [63:0] STEPS = 64'h8076_0000_5043_2010;

  always #5 i_ref_clk = ~i_ref_clk;

  equalizer_control_register_bank dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_reg_hit(hit), .i_pins(pins), .o_eff(eff));

  eq_host_model host (
    .i_ref_clk(i_ref_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));

  // ====
  // Reference model of the effective settings
  function automatic eff_set_t model(input pin_set_t p);
    eff_set_t e;
    logic     m;
    m = shadow[0][0];
    e = '0;
    e.output_disable        = m ? shadow[0][3] : p.output_disable_pin;
    e.loss_range_high       = m ? shadow[0][2] : p.loss_range_pin;
    e.offset_cancel_disable = m & shadow[0][1];
    e.swing_reg_active      = m & ~shadow[0][6];
    e.deemph_reg_active     = m & ~shadow[0][5];
    e.deemph_code  = e.deemph_reg_active ? shadow[2][3:0] : {2'b00, p.emphasis_pins};
    e.deemph_steps = e.deemph_reg_active ? STEPS[4*shadow[2][3:0] +: 4] : 4'h0;
    e.threshold_reg_active = m & ~shadow[0][4];
    e.threshold_code = e.threshold_reg_active ? shadow[1] : p.threshold_voltage_pin;
    e.threshold_shift_neg = e.threshold_code > 8'h80;
    e.threshold_shift_mag = (e.threshold_code == 8'h00) ? 7'h00 :
      e.threshold_code[7] ? e.threshold_code[6:0] : 7'(8'h80 - e.threshold_code);
    e.bandwidth_from_code = m & shadow[7][7];
    e.bandwidth_code = e.bandwidth_from_code ? shadow[7][3:0] : 4'h0;
    e.loss_level_reg_active = m & ~shadow[0][7];
    e.loss_level_code = !e.loss_level_reg_active ? p.loss_level_voltage_pin :
      shadow[11][7] ? shadow[11][6:0] : 7'h00;
    return e;
  endfunction

  // ====
  // Access tasks
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    host.xfer(a, d, 1'b1, 1'b0, q, v);
    case (a)
      4'h0, 4'h1, 4'hb: shadow[a] = d;
      4'h2:             shadow[a] = d & 8'h0f;
      4'h7:             shadow[a] = d & 8'h8f;
      default:          shadow[a] = 8'h00;
    endcase
  endtask

  task automatic rreg(input logic [3:0] a);
    eff_set_t   m;
    logic [7:0] e;
    m = model(pins);
    e = (a == 4'he) ? {4'h0, m.bandwidth_code} :
        (a == 4'hf) ? {1'b0, m.loss_level_code} : shadow[a];
    host.xfer(a, 8'h00, 1'b0, 1'b1, q, v);
    `CHK(v, 1'b1)
    `CHK(q, e)
    `CHK(hit, !(a inside {[4'h3:4'h6]}))
  endtask

  task automatic chk_eff;
    @(negedge i_ref_clk);
    `CHK(eff, model(pins))
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ====
  // Tests
  initial begin
    repeat (5) @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    chk_eff();
    for (int a = 0; a < 16; a++) begin
      rreg(4'(a));
    end
    for (int a = 0; a < 16; a++) begin
      wreg(4'(a), 8'hff);
    end
    for (int a = 0; a < 16; a++) begin
      rreg(4'(a));
    end
    chk_eff();
    host.xfer(4'h0, 8'h01, 1'b1, 1'b1, q, v);
    shadow[0] = 8'h01;
    `CHK(q, 8'hff)
    for (int i = 0; i < 8; i++) begin
      pins = ~pins;
      wreg(4'h0, 8'h01 | (8'h01 << i));
      chk_eff();
      rreg(4'hf);
    end
    wreg(4'h0, 8'h01);
    foreach (thr_codes[i]) begin
      wreg(4'h1, thr_codes[i]);
      chk_eff();
    end
    for (int i = 0; i < 16; i++) begin
      wreg(4'h2, {4'ha, 4'(i)});
      chk_eff();
    end
    foreach (sel_codes[i]) begin
      wreg(4'h7, sel_codes[i]);
      wreg(4'hb, sel_codes[i]);
      chk_eff();
      rreg(4'he);
      rreg(4'hf);
    end
    wreg(4'h0, 8'h00);
    chk_eff();
    rreg(4'he);
    // Frozen bank takes nothing, yet reset still clears every register
    @(negedge i_ref_clk);
    i_clk_en = 1'b0;
    host.xfer(4'h0, 8'hff, 1'b1, 1'b1, q, v);
    `CHK(v, 1'b0)
    i_rst_b = 1'b0;
    @(negedge i_ref_clk);
    i_rst_b = 1'b1;
    i_clk_en = 1'b1;
    shadow = '{default: 8'h00};
    chk_eff();
    for (int a = 0; a < 16; a++) begin
      rreg(4'(a));
    end
    test_done();
  end

  // Whole run is a few hundred cycles, so this only fires on a hang
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    fail_count++;
    test_done();
  end
endmodule

bind equalizer_control_register_bank equalizer_control_register_bank_props chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_reg_hit(o_reg_hit),
  .i_pins(i_pins), .o_eff(o_eff));
